// ===== lcdrc_ctrl.sv
`timescale 1ns/100ps
module lcdrc_ctrl #(
	parameter bit           FOUR_LINES = 1'b1,
	parameter int           DIV_M      = lcdrc_pkg::DIV_DEPTH,
	parameter int           PRE_CYC    = lcdrc_pkg::CP_DIV_CYC,
	parameter logic [127:0] TABLE      = lcdrc_pkg::LOOKUP_DEFAULT
) (
	input  wire logic                            clock,
	input  wire logic                            rst_b,
	input  wire logic [3:0]                      regAddr,
	input  wire logic [lcdrc_pkg::WORD_W-1:0]    regWrData,
	input  wire logic                            regWrite,
	input  wire logic                            regRead,
	input  wire logic                            auxPortAWrite,
	input  wire logic                            holdFlag,
	output logic      [lcdrc_pkg::WORD_W-1:0]    regRdData,
	output logic      [lcdrc_pkg::SEG_COUNT-1:0] segDrive,
	output logic      [lcdrc_pkg::LINES_FOUR-1:0] comDrive,
	output logic                                 panelSupplyOn,
	output logic      [lcdrc_pkg::WORD_W-1:0]    auxPortA,
	output logic      [lcdrc_pkg::WORD_W-1:0]    sharedPortB
);
	import lcdrc_pkg::*;

	//--------------------------------------------------------------
	// derived constants
	//--------------------------------------------------------------
	localparam logic [PRE_W-1:0]   PRE_LAST   = PRE_W'(PRE_CYC - 1);
	localparam logic [STAGE_W-1:0] STAGE_LAST = STAGE_W'((1 << DIV_M) - 1);
	localparam logic [1:0]         LINE_LAST  = FOUR_LINES ? 2'(LINES_FOUR - 1)
	                                                       : 2'(LINES_THREE - 1);

	lcdrc_state_s        st_q;
	lcdrc_state_s        st_d;
	logic [WORD_W-1:0]   lookupSlice;
	logic                wrCommand;
	logic                wrDisplay;
	logic                wrLookup;
	logic                rdLookup;
	logic                cpTick;
	logic                lineTick;

	//--------------------------------------------------------------
	// helpers
	//--------------------------------------------------------------

	// one-hot select of the active backplane line
	function automatic logic [3:0] lineMask(input logic [1:0] idx);
		logic [3:0] m;
		m = 4'h0;
		m[idx] = 1'b1;
		return m;
	endfunction : lineMask

	// segment pattern for one backplane line
	function automatic logic [SEG_COUNT-1:0] segPattern(input lcdrc_words_t w, input logic [1:0] idx);
		logic [SEG_COUNT-1:0] p;
		p = '0;
		for (int i = 0; i < SEG_COUNT; i++) begin
			p[i] = w[i][idx];
		end
		return p;
	endfunction : segPattern

	//--------------------------------------------------------------
	// register port decode
	//--------------------------------------------------------------

	// write and read strobes per register number
	assign wrCommand = regWrite && regAddr == REG_COMMAND;
	assign wrDisplay = regWrite && regAddr == REG_DISPLAY_B;
	assign wrLookup  = regWrite && regAddr == REG_LOOKUP;
	assign rdLookup  = regRead && regAddr == REG_LOOKUP;

	//--------------------------------------------------------------
	// lookup decoder
	//--------------------------------------------------------------

	// readout restarts on a fresh code write or on reset
	lcdrc_lookup #(
		.FOUR_LINES (FOUR_LINES),
		.TABLE      (TABLE)
	) u_lookup (
		.clock     (clock),
		.rst_b     (rst_b),
		.codeWrite (wrLookup),
		.codeIn    (regWrData),
		.sliceRead (rdLookup),
		.slice     (lookupSlice)
	);

	//--------------------------------------------------------------
	// timebase
	//--------------------------------------------------------------

	// internal clock enable and end of each backplane period
	assign cpTick   = st_q.preCount == PRE_LAST;
	assign lineTick = cpTick && st_q.stageCount == STAGE_LAST;

	//--------------------------------------------------------------
	// next state
	//--------------------------------------------------------------
	always_comb begin
		st_d = st_q;

		// prescaler to the internal clock rate
		if (cpTick) begin
			st_d.preCount = '0;
		end else begin
			st_d.preCount = st_q.preCount + PRE_W'(1);
		end

		// divider stages, 2^m internal clocks per line
		if (lineTick) begin
			st_d.stageCount = '0;
		end else if (cpTick) begin
			st_d.stageCount = st_q.stageCount + STAGE_W'(1);
		end

		// backplane line counter, n lines per frame
		if (lineTick) begin
			if (st_q.line == LINE_LAST) begin
				st_d.line = 2'h0;
			end else begin
				st_d.line = st_q.line + 2'h1;
			end
		end

		// command register
		if (wrCommand) begin
			st_d.scan   = regWrData[CMD_SCAN_BIT];
			st_d.dispEn = regWrData[CMD_DISP_BIT];
		end

		// register 6 steers to shift register or port B
		if (wrDisplay) begin
			if (!st_q.scan) begin
				// first word written ends at the top position
				st_d.shiftWords = {st_q.shiftWords[SEG_COUNT-2:0], regWrData};
			end else begin
				st_d.portB = regWrData;
			end
		end

		// port A latch, independent of scan
		if (auxPortAWrite) begin
			st_d.portA = regWrData;
		end

		// shown data follows the shift register only while scanning
		if (st_q.scan) begin
			st_d.shownWords = st_q.shiftWords;
		end

		// blank once a line switch falls inside a load period
		if (st_d.scan) begin
			st_d.blank = 1'b0;
		end else if (lineTick) begin
			st_d.blank = 1'b1;
		end

		// panel supply switch
		if (st_d.scan) begin
			st_d.supplyOn = 1'b1;
		end else if (holdFlag) begin
			st_d.supplyOn = 1'b0;
		end

		// register read data, write-only ports read as zero
		if (regRead) begin
			case (regAddr)
				REG_COMMAND: st_d.rdData = {2'b00, st_q.dispEn, st_q.scan};
				REG_LOOKUP:  st_d.rdData = lookupSlice;
				default:     st_d.rdData = 4'h0;
			endcase
		end

		// panel drive levels
		if (!st_d.supplyOn) begin
			st_d.segOut = {SEG_COUNT{1'b1}};
			st_d.comOut = 4'hF;
		end else begin
			st_d.comOut = lineMask(st_d.line);
			if (st_d.blank || !st_d.dispEn) begin
				st_d.segOut = '0;
			end else begin
				st_d.segOut = segPattern(st_d.shownWords, st_d.line);
			end
		end
	end

	//--------------------------------------------------------------
	// state register
	//--------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= STATE_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	//--------------------------------------------------------------
	// outputs
	//--------------------------------------------------------------

	// every output straight from the state register
	assign regRdData     = st_q.rdData;
	assign segDrive      = st_q.segOut;
	assign comDrive      = st_q.comOut;
	assign panelSupplyOn = st_q.supplyOn;
	assign auxPortA      = st_q.portA;
	assign sharedPortB   = st_q.portB;

endmodule : lcdrc_ctrl

// ===== lcdrc_ctrl_monitor.sv
`timescale 1ns/100ps
module lcdrc_ctrl_monitor #(
	parameter bit           FOUR_LINES = 1'b1,
	parameter int           DIV_M      = 9,
	parameter int           PRE_CYC    = 250,
	parameter logic [127:0] TABLE      = lcdrc_pkg::LOOKUP_DEFAULT
) (
	input wire logic        clock,
	input wire logic        rst_b,
	input wire logic [3:0]  regAddr,
	input wire logic [3:0]  regWrData,
	input wire logic        regWrite,
	input wire logic        regRead,
	input wire logic        auxPortAWrite,
	input wire logic        holdFlag,
	input wire logic [3:0]  regRdData,
	input wire logic [23:0] segDrive,
	input wire logic [3:0]  comDrive,
	input wire logic        panelSupplyOn,
	input wire logic [3:0]  auxPortA,
	input wire logic [3:0]  sharedPortB
);
	import lcdrc_pkg::*;
	localparam int LINE_CYC = (2 ** DIV_M) * PRE_CYC;
	logic [31:0] gap_q;
	logic        real_q;
	logic [3:0]  nextCom;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	// ------------------------------------------------------------
	// line timing helpers
	// ------------------------------------------------------------
	// next backplane line after the current one
	assign nextCom = FOUR_LINES ? {comDrive[2:0], comDrive[3]} : {1'b0, comDrive[1:0], comDrive[2]};
	// cycles since the lines last moved; whether that move was a true step
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			gap_q  <= '0;
			real_q <= 1'b0;
		end else begin
			gap_q  <= $changed(comDrive) ? '0 : gap_q + 32'h1;
			real_q <= panelSupplyOn && ($changed(comDrive) ? $past(comDrive) != 4'hF : real_q);
		end
	end
	sequence sLineStep;
		$changed(comDrive) && $past(comDrive) != 4'hF && panelSupplyOn && $past(panelSupplyOn);
	endsequence
	sequence sScanClear;
		regWrite && regAddr == REG_COMMAND && !regWrData[CMD_SCAN_BIT] ##1 holdFlag && !regWrite;
	endsequence
	sequence sLookup;
		regWrite && regAddr == REG_LOOKUP ##2 regRead && regAddr == REG_LOOKUP;
	endsequence
	property p_lineNext; sLineStep |-> comDrive == $past(nextCom); endproperty
	property p_lineGap; sLineStep |-> !real_q || gap_q == LINE_CYC - 1; endproperty
	property p_lineBound; real_q && panelSupplyOn |-> gap_q < LINE_CYC; endproperty
	property p_supplyOff; !panelSupplyOn |-> (&segDrive) && comDrive == 4'hF; endproperty
	property p_supplyHeld;
		(regWrite && regAddr == REG_COMMAND && regWrData[CMD_SCAN_BIT]) || (panelSupplyOn && !holdFlag)
			|=> panelSupplyOn;
	endproperty
	property p_holdOpens; sScanClear |=> !panelSupplyOn; endproperty
	property p_portA; 1'b1 |=> auxPortA == ($past(auxPortAWrite) ? $past(regWrData) : $past(auxPortA)); endproperty
	property p_portB; !(regWrite && regAddr == REG_DISPLAY_B) |=> $stable(sharedPortB); endproperty
	property p_cmdRead; regRead && regAddr == REG_COMMAND |=> regRdData[3:2] == 2'h0; endproperty
	property p_lookupLow;
		sLookup |=> regRdData == (FOUR_LINES ? TABLE[8 * $past(regWrData, 3) +: 4]
			: {1'b0, TABLE[8 * $past(regWrData, 3) +: 3]});
	endproperty
	a_lineNext: assert property (p_lineNext)
		else $error("backplane line out of order");
	a_lineGap: assert property (p_lineGap)
		else $error("line period wrong");
	a_lineBound: assert property (p_lineBound)
		else $error("line did not advance");
	a_supplyOff: assert property (p_supplyOff)
		else $error("drive lines not high with supply open");
	a_supplyHeld: assert property (p_supplyHeld)
		else $error("supply switch opened");
	a_holdOpens: assert property (p_holdOpens)
		else $error("supply stayed closed in hold");
	a_portA: assert property (p_portA)
		else $error("port A latch wrong");
	a_portB: assert property (p_portB)
		else $error("port B changed without write");
	a_cmdRead: assert property (p_cmdRead)
		else $error("command read upper bits set");
	a_lookupLow: assert property (p_lookupLow)
		else $error("lookup low slice wrong");
endmodule : lcdrc_ctrl_monitor
bind lcdrc_ctrl lcdrc_ctrl_monitor #(.FOUR_LINES(FOUR_LINES), .DIV_M(DIV_M), .PRE_CYC(PRE_CYC), .TABLE(TABLE)) u_mon (.*);

// ===== lcdrc_ctrl_tb.sv
`timescale 1ns/100ps
`define CHK(act, exp) begin samples_checked++; if ((act) !== (exp)) begin num_errors++; \
	$display("mismatch at %0t: got %h expected %h", $time, act, exp); end end
module lcdrc_ctrl_tb;
	import lcdrc_pkg::*;
	logic             clock, rst_b, regWrite, regRead, auxPortAWrite, holdFlag, panelSupplyOn;
	logic [3:0]       regAddr, regWrData, regRdData, auxPortA, sharedPortB, comDrive, d;
	logic [3:0]       regRdData3;
	logic [23:0]      segDrive;
	logic [3:0][23:0] litLines;
	logic [3:0]       words [24];
	int               num_errors = 0;
	int               samples_checked = 0;
	lcdrc_ctrl #(.FOUR_LINES(1'b1), .DIV_M(2), .PRE_CYC(2)) u_dut (.*);
	// three-line build on the same stimulus, for the sliced lookup readout
	lcdrc_ctrl #(.FOUR_LINES(1'b0), .DIV_M(2), .PRE_CYC(2)) u_dut3 (.clock(clock), .rst_b(rst_b),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.auxPortAWrite(auxPortAWrite), .holdFlag(holdFlag), .regRdData(regRdData3), .segDrive(),
		.comDrive(), .panelSupplyOn(), .auxPortA(), .sharedPortB());
	lcdrc_panel_model u_panel (.clock(clock), .segDrive(segDrive), .comDrive(comDrive),
		.supplyOn(panelSupplyOn), .litLines(litLines));
	// ------------------------------------------------------------
	// clock, tasks and expectations
	// ------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	task automatic wr(input logic [3:0] a, input logic [3:0] v);
		@(posedge clock);
		regAddr   <= a;
		regWrData <= v;
		regWrite  <= 1'b1;
		@(posedge clock);
		regWrite  <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [3:0] v);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1 v = regRdData;
	endtask : rd
	function automatic logic [23:0] expLine(input int j);
		for (int i = 0; i < 24; i++) expLine[i] = words[i][j];
	endfunction : expLine
	function automatic logic [3:0] lkSlice(input int c, input int n);
		return (n < 2) ? LOOKUP_DEFAULT[8 * c + 4 * n +: 4] : 4'h0;
	endfunction : lkSlice
	// three-line slices: bits 2..0, 5..3, 7..6, upper read bits zero
	function automatic logic [3:0] lk3(input int c, input int n);
		logic [7:0] r;
		r = LOOKUP_DEFAULT[8 * c +: 8];
		case (n)
			0:       return {1'b0, r[2:0]};
			1:       return {1'b0, r[5:3]};
			default: return {2'b00, r[7:6]};
		endcase
	endfunction : lk3
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test
	// hang guard
	initial begin
		repeat (5000) @(posedge clock);
		num_errors++;
		end_of_test();
	end
	// main sequence
	initial begin
		{rst_b, regWrite, regRead, auxPortAWrite, holdFlag} = '0;
		regAddr   = 4'h0;
		regWrData = 4'h0;
		void'($urandom(32'h30CA));
		repeat (16) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		#1 `CHK(panelSupplyOn, 1'b0)
		`CHK({auxPortA, sharedPortB, segDrive}, 32'h00FFFFFF)
		rd(REG_COMMAND, d);
		`CHK(d, 4'h0)
		$display("reset test done");
		for (int i = 0; i < 24; i++) words[i] = 4'($urandom);
		for (int i = 23; i >= 0; i--) wr(REG_DISPLAY_B, words[i]);
		wr(REG_COMMAND, 4'h3);
		#1 `CHK(panelSupplyOn, 1'b1)
		d = 4'($urandom);
		wr(REG_DISPLAY_B, d);
		#1 `CHK(sharedPortB, d)
		repeat (48) @(posedge clock);
		for (int j = 0; j < 4; j++)
			`CHK(litLines[j], expLine(j))
		@(posedge clock);
		regWrData     <= ~d;
		auxPortAWrite <= 1'b1;
		@(posedge clock);
		auxPortAWrite <= 1'b0;
		#1 `CHK(auxPortA, ~d)
		$display("load and port test done");
		for (int c = 0; c < 16; c++) begin
			wr(REG_LOOKUP, 4'(c));
			for (int n = 0; n < 3; n++) begin
				rd(REG_LOOKUP, d);
				`CHK(d, lkSlice(c, n))
				`CHK(regRdData3, lk3(c, n))
			end
		end
		wr(REG_LOOKUP, 4'h9);
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		rd(REG_LOOKUP, d);
		`CHK(d, lkSlice(9, 0))
		$display("lookup test done");
		wr(REG_COMMAND, 4'h3);
		wr(REG_COMMAND, 4'h2);
		repeat (20) @(posedge clock);
		#1 `CHK(segDrive, 24'h000000)
		`CHK(panelSupplyOn, 1'b1)
		wr(REG_COMMAND, 4'h3);
		holdFlag <= 1'b1;
		repeat (4) @(posedge clock);
		#1 `CHK(panelSupplyOn, 1'b1)
		wr(REG_COMMAND, 4'h2);
		@(posedge clock);
		#1 `CHK({panelSupplyOn, segDrive, comDrive}, 29'h0FFFFFFF)
		holdFlag <= 1'b0;
		$display("blank and hold test done");
		end_of_test();
	end
endmodule : lcdrc_ctrl_tb

// ===== lcdrc_lookup.sv
`timescale 1ns/100ps
module lcdrc_lookup #(
	parameter bit           FOUR_LINES = 1'b1,
	parameter logic [127:0] TABLE      = lcdrc_pkg::LOOKUP_DEFAULT
) (
	input  wire logic                         clock,
	input  wire logic                         rst_b,
	input  wire logic                         codeWrite,
	input  wire logic [lcdrc_pkg::WORD_W-1:0] codeIn,
	input  wire logic                         sliceRead,
	output logic      [lcdrc_pkg::WORD_W-1:0] slice
);
	import lcdrc_pkg::*;

	lcdrc_lk_s  lk_q;
	lcdrc_lk_s  lk_d;
	logic [7:0] result_q;

	//--------------------------------------------------------------
	// slice selection
	//--------------------------------------------------------------
	function automatic logic [3:0] pick(input logic [7:0] r, input logic [1:0] idx, input bit four);
		logic [3:0] v;
		v = 4'h0;
		if (four) begin
			case (idx)
				2'h0:    v = r[3:0];
				2'h1:    v = r[7:4];
				default: v = 4'h0;
			endcase
		end else begin
			case (idx)
				2'h0:    v = {1'b0, r[2:0]};
				2'h1:    v = {1'b0, r[5:3]};
				2'h2:    v = {2'b00, r[7:6]};
				default: v = 4'h0;
			endcase
		end
		return v;
	endfunction : pick

	assign slice = pick(result_q, lk_q.sliceIdx, FOUR_LINES);

	// slice pointer restarts on a code write, steps on each read until it holds at 3
	always_comb begin
		lk_d = lk_q;
		if (codeWrite) begin
			lk_d.sliceIdx = 2'h0;
		end else if (sliceRead && lk_q.sliceIdx != 2'h3) begin
			lk_d.sliceIdx = lk_q.sliceIdx + 2'h1;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			lk_q <= LK_RESET;
		end else begin
			lk_q <= lk_d;
		end
	end

	// result register, deliberately outside reset
	always_ff @(posedge clock) begin
		if (codeWrite) begin
			result_q <= TABLE[{codeIn, 3'b000} +: 8];
		end
	end

endmodule : lcdrc_lookup

// ===== lcdrc_panel_model.sv
`timescale 1ns/100ps
module lcdrc_panel_model (
	input  wire logic [lcdrc_pkg::SEG_COUNT-1:0]  segDrive,
	input  wire logic [lcdrc_pkg::LINES_FOUR-1:0] comDrive,
	input  wire logic                             clock,
	input  wire logic                             supplyOn,
	output logic      [3:0][23:0]                 litLines
);
	import lcdrc_pkg::*;
	// segments seen while one line is active; a 1 lights, lines keep their last capture with supply cut
	always_ff @(posedge clock) begin
		for (int j = 0; j < LINES_FOUR; j++) begin
			if (supplyOn && comDrive == 4'(1 << j)) begin
				litLines[j] <= segDrive;
			end
		end
	end
endmodule : lcdrc_panel_model

// ===== lcdrc_pkg.sv
package lcdrc_pkg;

	//--------------------------------------------------------------
	// register numbers on the core's register port
	//--------------------------------------------------------------
	localparam logic [3:0] REG_COMMAND     = 4'h3;
	localparam logic [3:0] REG_DISPLAY_B   = 4'h6;
	localparam logic [3:0] REG_LOOKUP      = 4'h7;

	// command register field positions
	localparam int CMD_SCAN_BIT = 0;
	localparam int CMD_DISP_BIT = 1;

	//--------------------------------------------------------------
	// panel geometry
	//--------------------------------------------------------------
	localparam int SEG_COUNT   = 24;
	localparam int WORD_W      = 4;
	localparam int LINES_FOUR  = 4;
	localparam int LINES_THREE = 3;

	//--------------------------------------------------------------
	// timing
	//--------------------------------------------------------------
	localparam longint CLOCK_HZ    = 50000000;
	localparam longint INT_CLK_HZ  = 200000;
	localparam int     CP_DIV_CYC  = int'(CLOCK_HZ / INT_CLK_HZ);
	localparam int     DIV_DEPTH   = 9;
	localparam int     PRE_W       = 8;
	localparam int     STAGE_W     = 16;

	//--------------------------------------------------------------
	// lookup decoder contents, entry i in bits 8*i+7 : 8*i
	//--------------------------------------------------------------
	localparam logic [127:0] LOOKUP_DEFAULT = 128'h0F0E0D0C0B0A09080706050403020100;

	typedef logic [SEG_COUNT-1:0][WORD_W-1:0] lcdrc_words_t;

	// controller state
	typedef struct packed {
		lcdrc_words_t               shiftWords;
		lcdrc_words_t               shownWords;
		logic                       scan;
		logic                       dispEn;
		logic                       supplyOn;
		logic                       blank;
		logic [PRE_W-1:0]           preCount;
		logic [STAGE_W-1:0]         stageCount;
		logic [1:0]                 line;
		logic [WORD_W-1:0]          portA;
		logic [WORD_W-1:0]          portB;
		logic [WORD_W-1:0]          rdData;
		logic [SEG_COUNT-1:0]       segOut;
		logic [LINES_FOUR-1:0]      comOut;
	} lcdrc_state_s;

	// supply open at reset, so every drive line sits high
	localparam lcdrc_state_s STATE_RESET = '{
		shiftWords: '0, shownWords: '0, scan: 1'b0, dispEn: 1'b0,
		supplyOn: 1'b0, blank: 1'b0, preCount: '0, stageCount: '0,
		line: 2'h0, portA: 4'h0, portB: 4'h0, rdData: 4'h0,
		segOut: {SEG_COUNT{1'b1}}, comOut: 4'hF};

	// lookup readout state
	typedef struct packed {
		logic [1:0] sliceIdx;
	} lcdrc_lk_s;

	localparam lcdrc_lk_s LK_RESET = '{sliceIdx: 2'h0};

endpackage : lcdrc_pkg
